/* File: ccs_counter_ctl.sv */
// counter control source selection, output source mode and input conditioning selectors
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

// Functional notes
// R1 - configuration held in contiguous single-bit registers
// R2 - counter A pin 1 destination from upper selector
// R3 - counter A pin 2 destination from lower selector
// R4 - counter B pin 1 destination from upper selector
// R5 - counter B pin 2 destination from lower selector
// R6 - code zero ladder; equal pairs force control low
// R7 - latch or clear pin 1 codes route
// R8 - enable or load pin 1 codes route
// R9 - mode zero: outputs follow output register
// R10 - mode one: comparisons drive outputs 1,2,5,6
// R11 - threshold selector picks 12, 6, 1.4, 0 V
// R12 - filter code 00 passes up to 1 MHz
// R13 - filter code 01 limits to 100 kHz
// R14 - filter high bit set limits to 10 kHz
// R15 - override program writes every configuration bit
// R16 - power-up configuration until override bit set
// R17 - counter B mirrors counter A routing
// R18 - pins synchronised and filtered before routing
module ccs_counter_ctl #(
  parameter int ADDR_W = 8,
  parameter logic [3:0] PWR_SEL_A = 4'h0,
  parameter logic [3:0] PWR_SEL_B = 4'h0,
  parameter logic PWR_OUT_SRC = 1'b0,
  parameter logic [1:0] PWR_THR = 2'h0,
  parameter logic [1:0] PWR_FLT = 2'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extPinA1,
  input wire logic extPinA2,
  input wire logic extPinB1,
  input wire logic extPinB2,
  input wire logic [3:0] cmpResult,
  output logic loadA,
  output logic enableA,
  output logic clearA,
  output logic latchA,
  output logic loadB,
  output logic enableB,
  output logic clearB,
  output logic latchB,
  output logic [7:0] outPins,
  output logic [1:0] threshSel,
  output logic [1:0] filterSel
);

  // software-visible state
  logic ovr_r;
  logic ovr_nxt;
  logic [7:0] ladder_r;
  logic [7:0] ladder_nxt;
  logic [3:0] selA_r;
  logic [3:0] selA_nxt;
  logic [3:0] selB_r;
  logic [3:0] selB_nxt;
  logic [4:0] cond_r;
  logic [4:0] cond_nxt;
  logic [7:0] outReg_r;
  logic [7:0] outReg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // effective configuration and routed results
  logic [3:0] effSelA;
  logic [3:0] effSelB;
  logic effOutSrc;
  logic [1:0] effThr;
  logic [1:0] effFlt;
  ccs_pkg::ccs_flt_t fltMode;
  ccs_pkg::ccs_thr_t thrMode;
  logic [3:0] pinClean;
  logic [3:0] routeA;
  logic [3:0] routeB;
  logic [3:0] ctlA_r;
  logic [3:0] ctlA_nxt;
  logic [3:0] ctlB_r;
  logic [3:0] ctlB_nxt;
  logic [7:0] outPins_r;
  logic [7:0] outPins_nxt;
  logic [1:0] thr_r;
  logic [1:0] thr_nxt;
  logic [1:0] flt_r;
  logic [1:0] flt_nxt;

  logic setupPh;
  logic wrEn;
  logic hit;

  // true when the offset names one of the mapped registers
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    case (8'(a))
      `CCS_OFF_OVERRIDE, `CCS_OFF_LADDER, `CCS_OFF_SELECT,
      `CCS_OFF_COND, `CCS_OFF_OUTREG, `CCS_OFF_STATUS: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // apb: no wait states; writes land at the access edge, reads are captured at setup
  assign setupPh = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign hit = isMapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;

  // R1 register writes
  // every configuration bit is one flip-flop in a small group of words
  always_comb begin
    ovr_nxt = ovr_r;
    ladder_nxt = ladder_r;
    selA_nxt = selA_r;
    selB_nxt = selB_r;
    cond_nxt = cond_r;
    outReg_nxt = outReg_r;
    if (wrEn) begin
      case (8'(paddr))
        `CCS_OFF_OVERRIDE: ovr_nxt = pwdata[0];
        `CCS_OFF_LADDER: ladder_nxt = pwdata[7:0];
        `CCS_OFF_SELECT: begin
          selA_nxt = pwdata[3:0];
          selB_nxt = pwdata[7:4];
        end
        `CCS_OFF_COND: cond_nxt = pwdata[4:0];
        `CCS_OFF_OUTREG: outReg_nxt = pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read data; unmapped offsets and unused upper bits read as zero; status bits read their live values
  always_comb begin
    prdata_nxt = prdata_r;
    if (setupPh && !pwrite) begin
      case (8'(paddr))
        `CCS_OFF_OVERRIDE: prdata_nxt = {31'h0000_0000, ovr_r};
        `CCS_OFF_LADDER: prdata_nxt = {24'h00_0000, ladder_r};
        `CCS_OFF_SELECT: prdata_nxt = {24'h00_0000, selB_r, selA_r};
        `CCS_OFF_COND: prdata_nxt = {27'h000_0000, cond_r};
        `CCS_OFF_OUTREG: prdata_nxt = {24'h00_0000, outReg_r};
        `CCS_OFF_STATUS: prdata_nxt = {8'h00, flt_r, thr_r, pinClean, outPins_r, ctlB_r, ctlA_r};
        default: prdata_nxt = `CCS_RST_WORD;
      endcase
    end
  end

  // R16 power-up configuration stays in force until the override bit is set
  // the program must then supply every selector itself, nothing is merged
  assign effSelA = ovr_r ? selA_r : PWR_SEL_A;
  assign effSelB = ovr_r ? selB_r : PWR_SEL_B;
  assign effOutSrc = ovr_r ? cond_r[`CCS_COND_OUTSRC] : PWR_OUT_SRC;
  assign effThr = ovr_r ? cond_r[`CCS_COND_THR_LO +: 2] : PWR_THR;
  assign effFlt = ovr_r ? cond_r[`CCS_COND_FLT_LO +: 2] : PWR_FLT;

  // R12 R13 R14 filter strength; low bit ignored once the high bit is set
  always_comb begin
    case (effFlt)
      2'b00: fltMode = ccs_pkg::FLT_HIGH;
      2'b01: fltMode = ccs_pkg::FLT_MEDIUM;
      default: fltMode = ccs_pkg::FLT_LOW;
    endcase
  end

  // R11 threshold level code, high selector bit first
  always_comb begin
    case (effThr)
      2'b00: thrMode = ccs_pkg::THR_12V;
      2'b01: thrMode = ccs_pkg::THR_6V;
      2'b10: thrMode = ccs_pkg::THR_1V4;
      default: thrMode = ccs_pkg::THR_0V;
    endcase
  end

  // R18 pins cleaned before routing; adds latency of the filter hold time
  ccs_pin_filter #(
    .W(4)
  ) uFilter (
    .clk(clk),
    .rst(rst),
    .pinRaw({extPinB2, extPinB1, extPinA2, extPinA1}),
    .fltMode(fltMode),
    .pinClean(pinClean)
  );

  // R2 R3 counter A routing from its selector pairs
  ccs_route uRouteA (
    .sel(effSelA),
    .ladder(ladder_r[3:0]),
    .pin1(pinClean[0]),
    .pin2(pinClean[1]),
    .ctl(routeA)
  );

  // R4 R5 R17 counter B uses the same table with its own pins and bits
  ccs_route uRouteB (
    .sel(effSelB),
    .ladder(ladder_r[7:4]),
    .pin1(pinClean[2]),
    .pin2(pinClean[3]),
    .ctl(routeB)
  );

  // R9 R10 output source; comparison bits land on outputs 1, 2, 5 and 6
  always_comb begin
    ctlA_nxt = routeA;
    ctlB_nxt = routeB;
    thr_nxt = 2'(thrMode);
    flt_nxt = effFlt;
    outPins_nxt = outReg_r;
    if (effOutSrc) begin
      outPins_nxt[0] = cmpResult[0];
      outPins_nxt[1] = cmpResult[1];
      outPins_nxt[4] = cmpResult[2];
      outPins_nxt[5] = cmpResult[3];
    end
  end

  // one register stage for everything the block holds and every output except pready and pslverr
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_r <= 1'b0;
      ladder_r <= `CCS_RST_BYTE;
      selA_r <= 4'h0;
      selB_r <= 4'h0;
      cond_r <= 5'h00;
      outReg_r <= `CCS_RST_BYTE;
      prdata_r <= `CCS_RST_WORD;
      ctlA_r <= 4'h0;
      ctlB_r <= 4'h0;
      outPins_r <= `CCS_RST_BYTE;
      thr_r <= 2'h0;
      flt_r <= 2'h0;
    end else begin
      ovr_r <= ovr_nxt;
      ladder_r <= ladder_nxt;
      selA_r <= selA_nxt;
      selB_r <= selB_nxt;
      cond_r <= cond_nxt;
      outReg_r <= outReg_nxt;
      prdata_r <= prdata_nxt;
      ctlA_r <= ctlA_nxt;
      ctlB_r <= ctlB_nxt;
      outPins_r <= outPins_nxt;
      thr_r <= thr_nxt;
      flt_r <= flt_nxt;
    end
  end

  assign loadA = ctlA_r[`CCS_CTL_LOAD];
  assign enableA = ctlA_r[`CCS_CTL_ENABLE];
  assign clearA = ctlA_r[`CCS_CTL_CLEAR];
  assign latchA = ctlA_r[`CCS_CTL_LATCH];
  assign loadB = ctlB_r[`CCS_CTL_LOAD];
  assign enableB = ctlB_r[`CCS_CTL_ENABLE];
  assign clearB = ctlB_r[`CCS_CTL_CLEAR];
  assign latchB = ctlB_r[`CCS_CTL_LATCH];
  assign outPins = outPins_r;
  assign threshSel = thr_r;
  assign filterSel = flt_r;

  AST_OVR_HOLD: assert property (@(posedge clk) disable iff (rst) // R16
    !ovr_r |-> (effSelA == PWR_SEL_A) && (effSelB == PWR_SEL_B) && (effFlt == PWR_FLT))
    else $error("runtime selector used before override");

  AST_SRC_REG: assert property (@(posedge clk) disable iff (rst) // R9
    !effOutSrc |=> outPins == $past(outReg_r))
    else $error("outputs not taken from output register");

  AST_SRC_CMP: assert property (@(posedge clk) disable iff (rst) // R10
    effOutSrc |=> {outPins[5], outPins[4], outPins[1], outPins[0]} == $past(cmpResult)
      && {outPins[7:6], outPins[3:2]} == {$past(outReg_r[7:6]), $past(outReg_r[3:2])})
    else $error("comparison results not on outputs 1,2,5,6");

  AST_CODE_ZERO: assert property (@(posedge clk) disable iff (rst) // R6
    effSelA == 4'h0 |=> {loadA, enableA, clearA, latchA} == $past(ladder_r[3:0]))
    else $error("code zero must follow ladder bits");

  AST_FORCE_LOW: assert property (@(posedge clk) disable iff (rst) // R6
    (effSelA == 4'h5) ##1 1'b1 |-> !clearA && (latchA == $past(ladder_r[`CCS_CTL_LATCH])))
    else $error("clear not forced low by code 0101");

  AST_PIN1_LATCH: assert property (@(posedge clk) disable iff (rst) // R7
    (effSelA[3:2] == 2'b00) && (effSelA[1:0] != 2'b00) |=> latchA == $past(pinClean[0]))
    else $error("latch not from pin 1");

  AST_PIN1_ENABLE: assert property (@(posedge clk) disable iff (rst) // R8
    (effSelA[3:2] == 2'b10) && (effSelA[1:0] != 2'b10) |=> enableA == $past(pinClean[0])
      && loadA == (($past(effSelA[1:0]) == 2'b11) ? $past(pinClean[1]) : $past(ladder_r[`CCS_CTL_LOAD])))
    else $error("enable not from pin 1");

  AST_B_MIRROR: assert property (@(posedge clk) disable iff (rst) // R17
    effSelB == 4'hF |=> !loadB && {enableB, clearB, latchB} == $past(ladder_r[6:4]))
    else $error("counter B code 1111 wrong");

  AST_FLT_LOW: assert property (@(posedge clk) disable iff (rst) // R14
    effFlt[1] |-> fltMode == ccs_pkg::FLT_LOW)
    else $error("high filter bit must select low frequency");

  AST_THR_CODE: assert property (@(posedge clk) disable iff (rst) // R11
    (effThr == 2'b10) ##1 (effThr == 2'b10) |-> threshSel == 2'(ccs_pkg::THR_1V4))
    else $error("threshold code mismatch");

  // R7 clear from pin 1
  AST_PIN1_CLEAR: assert property (@(posedge clk) disable iff (rst) // R7
    (effSelA[3:2] == 2'b01) && (effSelA[1:0] != 2'b01) |=> clearA == $past(pinClean[0]))
    else $error("clear not from pin 1");

  // R8 load from pin 1
  AST_PIN1_LOAD: assert property (@(posedge clk) disable iff (rst) // R8
    (effSelA[3:2] == 2'b11) && (effSelA[1:0] != 2'b11) |=> loadA == $past(pinClean[0]))
    else $error("load not from pin 1");

  // R3 latch from pin 2
  AST_PIN2_LATCH: assert property (@(posedge clk) disable iff (rst) // R3
    (effSelA[1:0] == 2'b00) && (effSelA[3:2] != 2'b00) |=> latchA == $past(pinClean[1]))
    else $error("latch not from pin 2");

  // R6 enable forced low
  AST_FORCE_EN: assert property (@(posedge clk) disable iff (rst) // R6
    effSelA == 4'hA |=> !enableA && (loadA == $past(ladder_r[`CCS_CTL_LOAD])))
    else $error("enable not forced low by code 1010");

  // R4 counter B pin 1
  AST_B_PIN1: assert property (@(posedge clk) disable iff (rst) // R4
    (effSelB[3:2] == 2'b00) && (effSelB[1:0] != 2'b00) |=> latchB == $past(pinClean[2]))
    else $error("counter B latch not from pin 1");

  // R5 counter B pin 2
  AST_B_PIN2: assert property (@(posedge clk) disable iff (rst) // R5
    (effSelB[1:0] == 2'b01) && (effSelB[3:2] != 2'b01) |=> clearB == $past(pinClean[3]))
    else $error("counter B clear not from pin 2");

  // R12 R13 R14 filter code shown
  AST_FLT_SHOWN: assert property (@(posedge clk) disable iff (rst) // R12
    1'b1 |=> filterSel == $past(effFlt))
    else $error("filter selector output wrong");

endmodule
`default_nettype wire

/* File: ccs_defs.svh */
// register offsets, field positions, reset values and timing counts for counter control routing
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// register byte offsets
`define CCS_OFF_OVERRIDE 8'h00
`define CCS_OFF_LADDER 8'h04
`define CCS_OFF_SELECT 8'h08
`define CCS_OFF_COND 8'h0C
`define CCS_OFF_OUTREG 8'h10
`define CCS_OFF_STATUS 8'h14

// field positions in the condition register
`define CCS_COND_OUTSRC 0
`define CCS_COND_THR_LO 1
`define CCS_COND_FLT_LO 3

// control bit positions inside one counter's control nibble
`define CCS_CTL_LATCH 0
`define CCS_CTL_CLEAR 1
`define CCS_CTL_ENABLE 2
`define CCS_CTL_LOAD 3

// reset values
`define CCS_RST_WORD 32'h0000_0000
`define CCS_RST_BYTE 8'h00

// timing: a pin must hold for half the period of the filter's top frequency
`define CCS_CLK_NS 25
`define CCS_HF_HALF_NS 500
`define CCS_MF_HALF_NS 5000
`define CCS_LF_HALF_NS 50000
`define CCS_HF_CYC (`CCS_HF_HALF_NS / `CCS_CLK_NS)
`define CCS_MF_CYC (`CCS_MF_HALF_NS / `CCS_CLK_NS)
`define CCS_LF_CYC (`CCS_LF_HALF_NS / `CCS_CLK_NS)
`define CCS_FLT_CNT_W 11

`endif

/* File: ccs_field_model.sv */
// field side model: external control pins and comparison results seen by the block
`timescale 1ns/10ps
`default_nettype none

module ccs_field_model (
  input wire logic clk,
  input wire logic [3:0] pinSet,
  input wire logic [3:0] cmpSet,
  output logic [3:0] pins,
  output logic [3:0] cmp
);
  // field levels change only after a clock edge, as a real wire is never phase aligned anyway
  always_ff @(posedge clk) begin
    pins <= pinSet;
    cmp <= cmpSet;
  end
endmodule
`default_nettype wire

/* File: ccs_pin_filter.sv */
// synchroniser and selectable noise filter for the external control pins
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module ccs_pin_filter #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pinRaw,
  input wire ccs_pkg::ccs_flt_t fltMode,
  output logic [W-1:0] pinClean
);

  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [W-1:0] clean_r;
  logic [W-1:0] clean_nxt;
  logic [`CCS_FLT_CNT_W-1:0] cnt_r [W];
  logic [`CCS_FLT_CNT_W-1:0] cnt_nxt [W];

  // hold time in cycles for a filter strength
  function automatic logic [`CCS_FLT_CNT_W-1:0] holdCycles(input ccs_pkg::ccs_flt_t m);
    case (m)
      ccs_pkg::FLT_HIGH: holdCycles = `CCS_FLT_CNT_W'(`CCS_HF_CYC);
      ccs_pkg::FLT_MEDIUM: holdCycles = `CCS_FLT_CNT_W'(`CCS_MF_CYC);
      default: holdCycles = `CCS_FLT_CNT_W'(`CCS_LF_CYC);
    endcase
  endfunction

  // R12 R13 R14 filter strength
  // a level must stay put for the hold time before it passes; shorter pulses are noise
  always_comb begin
    for (int i = 0; i < W; i++) begin
      clean_nxt[i] = clean_r[i];
      cnt_nxt[i] = '0;
      if (sync2_r[i] != clean_r[i]) begin
        if (cnt_r[i] >= holdCycles(fltMode) - `CCS_FLT_CNT_W'(1)) begin
          clean_nxt[i] = sync2_r[i];
        end else begin
          cnt_nxt[i] = cnt_r[i] + `CCS_FLT_CNT_W'(1);
        end
      end
    end
  end

  // R18 two-stage synchroniser, then filter state
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      clean_r <= '0;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
      clean_r <= clean_nxt;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign pinClean = clean_r;

  // a cleaned level only moves after the synchronised pin has disagreed for the hold time
  AST_FLT_HOLD: assert property (@(posedge clk) disable iff (rst) // R18
    (sync2_r[0] != clean_r[0]) && (cnt_r[0] == `CCS_FLT_CNT_W'(0)) && (fltMode == ccs_pkg::FLT_HIGH) |=>
    (clean_r[0] == $past(clean_r[0])))
    else $error("filtered pin moved before its hold time");

endmodule
`default_nettype wire

/* File: ccs_pkg.sv */
// types shared by the counter control routing block
`default_nettype none
package ccs_pkg;

  // noise filter strength, derived from the 2-bit filter selector
  typedef enum logic [1:0] {
    FLT_HIGH,
    FLT_MEDIUM,
    FLT_LOW
  } ccs_flt_t;

  // input threshold level, derived from the 2-bit threshold selector
  typedef enum logic [1:0] {
    THR_12V,
    THR_6V,
    THR_1V4,
    THR_0V
  } ccs_thr_t;

endpackage
`default_nettype wire

/* File: ccs_route.sv */
// routing of one counter's four controls between ladder bits and two external pins
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module ccs_route (
  input wire logic [3:0] sel,
  input wire logic [3:0] ladder,
  input wire logic pin1,
  input wire logic pin2,
  output logic [3:0] ctl
);

  logic [1:0] dst1;
  logic [1:0] dst2;

  // control nibble is {load, enable, clear, latch}; the upper selector pair picks where
  // pin 1 goes and the lower pair where pin 2 goes, both in the order latch, clear, enable, load
  assign dst1 = sel[3:2];
  assign dst2 = sel[1:0];

  // R6 R7 R8 control mapping
  always_comb begin
    ctl = ladder;
    if (dst1 == dst2) begin
      // equal pairs route no pin; the nonzero ones force their control low
      if (dst1 != 2'b00) begin
        ctl[dst1] = 1'b0;
      end
    end else begin
      ctl[dst1] = pin1;
      ctl[dst2] = pin2;
    end
  end

endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for counter control source selection
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pinSet = 4'h0;
  logic [3:0] cmpSet = 4'h0;
  logic [3:0] pins;
  logic [3:0] cmp;
  wire logic [3:0] ctlA;
  wire logic [3:0] ctlB;
  logic [7:0] outPins;
  logic [1:0] threshSel;
  logic [1:0] filterSel;
  logic [31:0] rd;
  logic er;
  logic seen;
  logic [3:0] pv;
  logic [7:0] lad;
  logic [7:0] expOut;
  int hold;
  int errors = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  ccs_counter_ctl u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extPinA1(pins[0]), .extPinA2(pins[1]), .extPinB1(pins[2]), .extPinB2(pins[3]), .cmpResult(cmp),
    .loadA(ctlA[3]), .enableA(ctlA[2]), .clearA(ctlA[1]), .latchA(ctlA[0]),
    .loadB(ctlB[3]), .enableB(ctlB[2]), .clearB(ctlB[1]), .latchB(ctlB[0]),
    .outPins(outPins), .threshSel(threshSel), .filterSel(filterSel));

  ccs_field_model u_field (.clk(clk), .pinSet(pinSet), .cmpSet(cmpSet), .pins(pins), .cmp(cmp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic endt(input string n);
    $display("test %s finished", n);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; the leading edge keeps psel from being assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected controls {load,enable,clear,latch}; selector halves name the pin destinations
  function automatic logic [3:0] route(input logic [3:0] s, input logic [3:0] l, input logic p1,
                                       input logic p2);
    logic [3:0] c;
    c = l;
    if (s[3:2] == s[1:0]) begin
      if (s != 4'h0) c[s[1:0]] = 1'b0;
    end else begin
      c[s[3:2]] = p1;
      c[s[1:0]] = p2;
    end
    return c;
  endfunction

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 8'(i * 4), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(er), 32'h0000_0000);
    end
    xfer(1'b0, 8'h18, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk(32'(er), 32'h0000_0001);
    endt("reset");
    pinSet <= 4'hF;
    xfer(1'b1, `CCS_OFF_LADDER, 32'h0000_00A5);
    xfer(1'b1, `CCS_OFF_SELECT, 32'h0000_0011);
    cyc(30);
    chk(32'(ctlA), 32'(route(4'h0, 4'h5, 1'b1, 1'b1)));
    chk(32'(ctlB), 32'(route(4'h0, 4'hA, 1'b1, 1'b1)));
    xfer(1'b0, `CCS_OFF_SELECT, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
    endt("power-up");
    // program writes every configuration bit, then takes over
    xfer(1'b1, `CCS_OFF_COND, 32'h0000_0000);
    xfer(1'b1, `CCS_OFF_OUTREG, 32'h0000_0000);
    xfer(1'b1, `CCS_OFF_OVERRIDE, 32'h0000_0001);
    // all sixteen codes for both counters, two pin and two ladder patterns
    for (int p = 0; p < 2; p++) begin
      pv = (p == 0) ? 4'h9 : 4'h6;
      pinSet <= pv;
      cyc(30);
      for (int l = 0; l < 2; l++) begin
        lad = (l == 0) ? 8'hA5 : 8'h5A;
        xfer(1'b1, `CCS_OFF_LADDER, 32'(lad));
        for (int s = 0; s < 16; s++) begin
          xfer(1'b1, `CCS_OFF_SELECT, 32'({s[3:0], s[3:0]}));
          cyc(2);
          chk(32'(ctlA), 32'(route(s[3:0], lad[3:0], pv[0], pv[1])));
          chk(32'(ctlB), 32'(route(s[3:0], lad[7:4], pv[2], pv[3])));
        end
      end
    end
    endt("routing");
    // short pin pulses dropped, long ones passed, per filter code
    xfer(1'b1, `CCS_OFF_SELECT, 32'h0000_0001);
    pinSet <= 4'h0;
    cyc(2100);
    for (int f = 0; f < 4; f++) begin
      xfer(1'b1, `CCS_OFF_COND, 32'((f << 3) | (f << 1)));
      cyc(2);
      chk(32'(threshSel), 32'(f));
      chk(32'(filterSel), 32'(f));
      hold = (f == 0) ? `CCS_HF_CYC : (f == 1) ? `CCS_MF_CYC : `CCS_LF_CYC;
      pinSet <= 4'h1;
      cyc(hold / 2);
      pinSet <= 4'h0;
      seen = 1'b0;
      repeat (hold + 10) begin
        @(posedge clk);
        seen |= ctlA[0];
      end
      chk(32'(seen), 32'h0000_0000);
      pinSet <= 4'h1;
      cyc(hold + 10);
      chk(32'(ctlA[0]), 32'h0000_0001);
      pinSet <= 4'h0;
      cyc(hold + 10);
    end
    endt("filter");
    // output register then comparison results on outputs 1,2,5,6
    xfer(1'b1, `CCS_OFF_COND, 32'h0000_0000);
    xfer(1'b1, `CCS_OFF_OUTREG, 32'h0000_00CC);
    cyc(2);
    chk(32'(outPins), 32'h0000_00CC);
    xfer(1'b1, `CCS_OFF_COND, 32'h0000_0001);
    for (int c = 5; c < 11; c += 5) begin
      cmpSet <= c[3:0];
      cyc(3);
      expOut = 8'hCC | {2'b00, c[3], c[2], 2'b00, c[1], c[0]};
      chk(32'(outPins), 32'(expOut));
      xfer(1'b0, `CCS_OFF_STATUS, 32'h0000_0000);
      chk(32'(rd[15:8]), 32'(expOut));
    end
    endt("outputs");
    final_report();
  end
endmodule
`default_nettype wire
